//--- rtl/nfc_pkg.sv
// nfc_pkg.sv: shared constants and types of the nand flash host port
package nfc_pkg;
  // clock rate in MHz and pin timing, figures in ns
  localparam int CLK_MHZ = 200;
  localparam int T_WC_NS = 45;   // write cycle
  localparam int T_WH_NS = 15;   // write strobe high hold
  localparam int T_RC_NS = 50;   // read cycle, slowest supply variant
  localparam int T_REH_NS = 15;  // output strobe high hold
  localparam int T_ADL_NS = 100; // last address to first data
  localparam int T_WB_NS = 100;  // write strobe high to busy
  localparam int T_WHR_NS = 60;  // write strobe high to output strobe low
  localparam int T_RHW_NS = 100; // output strobe high to write strobe low

  // least time in ns to whole clock cycles, never below one
  function automatic logic [7:0] ns_to_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 8'h01 : 8'(c);
  endfunction : ns_to_cyc

  localparam logic [7:0] CYC_WLO = ns_to_cyc(T_WC_NS - T_WH_NS);
  localparam logic [7:0] CYC_WHI = ns_to_cyc(T_WH_NS);
  localparam logic [7:0] CYC_RLO = ns_to_cyc(T_RC_NS - T_REH_NS);
  localparam logic [7:0] CYC_RHI = ns_to_cyc(T_REH_NS);
  localparam logic [7:0] CYC_ADL = ns_to_cyc(T_ADL_NS);
  localparam logic [7:0] CYC_WB = ns_to_cyc(T_WB_NS);
  localparam logic [7:0] CYC_WHR = ns_to_cyc(T_WHR_NS);
  localparam logic [7:0] CYC_RHW = ns_to_cyc(T_RHW_NS);

  // command bytes
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_READ_GO = 8'h30;
  localparam logic [7:0] CMD_ROUT = 8'h05;
  localparam logic [7:0] CMD_ROUT_GO = 8'he0;
  localparam logic [7:0] CMD_LOAD = 8'h80;
  localparam logic [7:0] CMD_RIN = 8'h85;
  localparam logic [7:0] CMD_PROG_GO = 8'h10;
  localparam logic [7:0] CMD_ID = 8'h90;
  localparam logic [7:0] CMD_STAT = 8'h70;

  // geometry and limits
  localparam logic [2:0] ADDR_LAST = 3'h4;   // five address cycles
  localparam logic [2:0] PART_MAX = 3'h4;    // partial programs per page
  localparam logic [11:0] ID_LEN = 12'h004;  // identification bytes
  localparam int ST_FAIL = 0;
  localparam int ST_RDY = 6;
  localparam int ST_WPN = 7;

  // register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_ADDR = 5'h04;
  localparam logic [4:0] OFS_LEN = 5'h08;
  localparam logic [4:0] OFS_DATA = 5'h0c;
  localparam logic [4:0] OFS_STAT = 5'h10;
  localparam logic [4:0] OFS_IDW = 5'h14;
  localparam logic [4:0] OFS_GEOM = 5'h18;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0, OP_READ = 3'h1, OP_RDCOL = 3'h2, OP_PROG = 3'h3,
    OP_WRCOL = 3'h4, OP_ID = 3'h5, OP_STAT = 3'h6
  } nfc_op_t;

  typedef enum logic [1:0] {
    K_CMD = 2'h0, K_ADR = 2'h1, K_WR = 2'h2, K_RD = 2'h3
  } nfc_kind_t;
endpackage : nfc_pkg

//--- rtl/nfc_cyc_if.sv
// nfc_cyc_if.sv: request and answer of one pin cycle between engine and strobe unit
`timescale 1ns/1ps
`default_nettype none
interface nfc_cyc_if;
  logic req;                  // one-cycle start pulse
  nfc_pkg::nfc_kind_t kind;   // command, address, write or read
  logic [7:0] wdata;          // byte to drive
  logic ce_on;                // engine wants chip enable low
  logic done;                 // one-cycle end pulse
  logic [7:0] rdata;          // byte caught on a read
  modport eng(output req, kind, wdata, ce_on, input done, rdata);
  modport cyc(input req, kind, wdata, ce_on, output done, rdata);
endinterface : nfc_cyc_if
`default_nettype wire

//--- rtl/nfc_cycle.sv
// nfc_cycle.sv: strobe unit that times one command, address or data cycle on the pins
`timescale 1ns/1ps
`default_nettype none
module nfc_cycle import nfc_pkg::*; (
  input wire logic mclk_i,
  input wire logic reset_i,
  nfc_cyc_if.cyc c,
  output logic ce_n_o,
  output logic cle_o,
  output logic ale_o,
  output logic we_n_o,
  output logic output_strobe_n_o,
  output logic [7:0] io_o,
  output logic io_oe_o,
  input wire logic [7:0] io_i
);
  typedef enum logic [1:0] {C_IDLE = 2'h0, C_LO = 2'h1, C_HI = 2'h2} nfc_cst_t;

  nfc_cst_t st_q, st_d;       // strobe phase
  logic [7:0] cnt_q, cnt_d;   // cycles left in phase
  logic rd_q, rd_d;           // current cycle is a read
  logic ce_n_q, ce_n_d, cle_q, cle_d, ale_q, ale_d, we_n_q, we_n_d, os_n_q, os_n_d;
  logic [7:0] io_q, io_d, rdat_q, rdat_d;
  logic oe_q, oe_d, done_q, done_d;

  // next phase: strobe low for the low time, then high for the hold time
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    rd_d = rd_q;
    cle_d = cle_q;
    ale_d = ale_q;
    we_n_d = we_n_q;
    os_n_d = os_n_q;
    io_d = io_q;
    oe_d = oe_q;
    rdat_d = rdat_q;
    done_d = 1'b0;
    // chip enable stays low while a cycle runs, even if the engine lets go
    ce_n_d = !(c.ce_on || st_q != C_IDLE);
    case (st_q)
      C_IDLE: begin
        if (c.req) begin
          cle_d = (c.kind == K_CMD);
          ale_d = (c.kind == K_ADR);
          io_d = c.wdata;
          oe_d = (c.kind != K_RD);
          rd_d = (c.kind == K_RD);
          ce_n_d = 1'b0;
          if (c.kind == K_RD) begin
            os_n_d = 1'b0;
            cnt_d = CYC_RLO;
          end else begin
            we_n_d = 1'b0;
            cnt_d = CYC_WLO;
          end
          st_d = C_LO;
        end
      end
      C_LO: begin
        if (cnt_q == 8'h01) begin
          // data is caught as the output strobe rises, after the access time
          if (rd_q) begin
            rdat_d = io_i;
          end
          we_n_d = 1'b1;
          os_n_d = 1'b1;
          cnt_d = rd_q ? CYC_RHI : CYC_WHI;
          st_d = C_HI;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      C_HI: begin
        if (cnt_q == 8'h01) begin
          // latches and data drive drop only after the hold time
          cle_d = 1'b0;
          ale_d = 1'b0;
          oe_d = 1'b0;
          done_d = 1'b1;
          st_d = C_IDLE;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      default: st_d = C_IDLE;
    endcase
  end

  // register the phase and every pin
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st_q <= C_IDLE;
      cnt_q <= 8'h00;
      rd_q <= 1'b0;
      ce_n_q <= 1'b1;
      cle_q <= 1'b0;
      ale_q <= 1'b0;
      we_n_q <= 1'b1;
      os_n_q <= 1'b1;
      io_q <= 8'h00;
      oe_q <= 1'b0;
      rdat_q <= 8'h00;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      rd_q <= rd_d;
      ce_n_q <= ce_n_d;
      cle_q <= cle_d;
      ale_q <= ale_d;
      we_n_q <= we_n_d;
      os_n_q <= os_n_d;
      io_q <= io_d;
      oe_q <= oe_d;
      rdat_q <= rdat_d;
      done_q <= done_d;
    end
  end

  assign c.done = done_q;
  assign c.rdata = rdat_q;
  assign ce_n_o = ce_n_q;
  assign cle_o = cle_q;
  assign ale_o = ale_q;
  assign we_n_o = we_n_q;
  assign output_strobe_n_o = os_n_q;
  assign io_o = io_q;
  assign io_oe_o = oe_q;
endmodule : nfc_cycle
`default_nettype wire

//--- rtl/nfc_top.sv
// nfc_top.sv: wishbone-controlled host engine for a byte-wide nand flash
// Functional notes
// - chip enable released while waiting for data
// - address bytes: column low, high, row low, high, then a zero byte
// - page read: setup, five addresses, confirm
// - at most four partial programs per page
// - pages programmed in ascending order per block
// - program load: input command, address, data bytes
// - random input command moves load pointer
// - no command but status while device busy
// - identification takes one zero address cycle
`timescale 1ns/1ps
`default_nettype none
module nfc_top import nfc_pkg::*; (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output wire logic ce_n_o,
  output wire logic cle_o,
  output wire logic ale_o,
  output wire logic we_n_o,
  output wire logic output_strobe_n_o,
  output logic wp_n_o,
  output wire logic [7:0] io_o,
  output wire logic io_oe_o,
  input wire logic [7:0] io_i,
  input wire logic rb_n_i
);
  typedef enum logic [3:0] {
    E_IDLE = 4'h0, E_CMD1 = 4'h1, E_ADDR = 4'h2, E_CMD2 = 4'h3, E_GAP = 4'h4,
    E_RDY = 4'h5, E_XFER = 4'h6, E_SCMD = 4'h7, E_SRD = 4'h8
  } nfc_est_t;

  nfc_cyc_if cy ();

  nfc_est_t st_q, st_d, gnx_q, gnx_d;   // engine state, state after a gap
  nfc_op_t op_q, op_d;                  // operation in hand
  logic conf_q, conf_d;                 // confirm after a load
  logic [27:0] adr_q, adr_d;            // flat byte address, column in 11:0
  logic [11:0] len_q, len_d;            // bytes to move
  logic [11:0] cnt_q, cnt_d;            // bytes moved so far
  logic [2:0] acnt_q, acnt_d;           // address cycle index
  logic [7:0] gap_q, gap_d;             // wait cycles left
  logic pend_q, pend_d;                 // a pin cycle is running
  logic req_q, req_d;
  nfc_kind_t kind_q, kind_d;
  logic [7:0] wd_q, wd_d;
  logic [7:0] wbyte_q, wbyte_d, rbyte_q, rbyte_d;
  logic wval_q, wval_d, rval_q, rval_d;  // data register full flags
  logic err_q, err_d;                   // last start refused
  logic [7:0] stat_q, stat_d;           // last status byte read
  logic [31:0] id_q, id_d;              // four identification bytes
  logic [15:0] lrow_q, lrow_d;          // last programmed row
  logic lrow_v_q, lrow_v_d;
  logic [2:0] pcnt_q, pcnt_d;           // partial programs on that row
  logic open_q, open_d;                 // load begun, not yet confirmed
  logic rdok_q, rdok_d;                 // a page sits in the device registers
  logic wpn_q, wpn_d;
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  // combinational helpers
  logic hit, stall, refuse;
  logic [31:0] mrg;                     // lane merge of an ADDR or LEN write
  nfc_op_t opn;

  // operations that stream bytes out of the device
  function automatic logic is_rd(input nfc_op_t op);
    return (op == OP_READ) || (op == OP_RDCOL) || (op == OP_ID);
  endfunction : is_rd

  // byte-lane merge of a register write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : merge

  // address byte for cycle idx; identification sends a single zero
  function automatic logic [7:0] abyte(input logic [2:0] idx, input logic [27:0] a,
                                       input nfc_op_t op);
    if (op == OP_ID) return 8'h00;
    case (idx)
      3'h0: return a[7:0];
      3'h1: return {4'h0, a[11:8]};
      3'h2: return a[19:12];
      3'h3: return a[27:20];
      default: return 8'h00;
    endcase
  endfunction : abyte

  // geometry decode of the fourth identification byte
  function automatic logic [31:0] geom(input logic [7:0] b);
    logic [31:0] g;
    g = 32'h0;
    case (b[1:0])
      2'h0: g[7:0] = 8'h01;
      2'h1: g[7:0] = 8'h02;
      default: g[7:0] = 8'h00;
    endcase
    case (b[5:4])
      2'h0: g[17:8] = 10'h040;
      2'h1: g[17:8] = 10'h080;
      2'h2: g[17:8] = 10'h100;
      default: g[17:8] = 10'h000;
    endcase
    g[22:18] = b[2] ? 5'h10 : 5'h08;
    g[23] = b[6];
    g[25:24] = ({b[7], b[3]} == 2'h0) ? 2'h0 : (({b[7], b[3]} == 2'h2) ? 2'h1 : 2'h2);
    return g;
  endfunction : geom

  // bus slave, start checks and command engine
  always_comb begin
    st_d = st_q; gnx_d = gnx_q; op_d = op_q; conf_d = conf_q;
    adr_d = adr_q; len_d = len_q; cnt_d = cnt_q; acnt_d = acnt_q;
    gap_d = gap_q; pend_d = pend_q; kind_d = kind_q; wd_d = wd_q;
    wbyte_d = wbyte_q; rbyte_d = rbyte_q; wval_d = wval_q; rval_d = rval_q;
    err_d = err_q; stat_d = stat_q; id_d = id_q; lrow_d = lrow_q;
    lrow_v_d = lrow_v_q; pcnt_d = pcnt_q; open_d = open_q; rdok_d = rdok_q;
    wpn_d = wpn_q; dat_d = dat_q;
    req_d = 1'b0;
    ack_d = 1'b0;
    refuse = 1'b0;
    opn = nfc_op_t'(wb_dat_i[2:0]);
    mrg = merge((wb_adr_i == OFS_ADDR) ? {4'h0, adr_q} : {20'h0, len_q}, wb_dat_i, wb_sel_i);
    hit = wb_cyc_i && wb_stb_i && !ack_q;
    // the data register holds the bus off until the engine can take or give a byte
    stall = (wb_adr_i == OFS_DATA) && (wb_we_i ? (wval_q && st_q != E_IDLE)
                                               : (st_q != E_IDLE && is_rd(op_q) && !rval_q));
    if (hit && !stall) begin
      ack_d = 1'b1;
      case (wb_adr_i)
        OFS_CTRL: dat_d = {27'h0, wpn_q, conf_q, op_q};
        OFS_ADDR: dat_d = {4'h0, adr_q};
        OFS_LEN: dat_d = {20'h0, len_q};
        OFS_DATA: dat_d = {24'h0, rbyte_q};
        OFS_STAT: dat_d = {16'h0, stat_q, 2'h0, stat_q[ST_WPN], stat_q[ST_RDY],
                           stat_q[ST_FAIL], err_q, rb_n_i, (st_q != E_IDLE)};
        OFS_IDW: dat_d = id_q;
        OFS_GEOM: dat_d = geom(id_q[31:24]);
        default: dat_d = 32'h0;
      endcase
      if (!wb_we_i && wb_adr_i == OFS_DATA) begin
        rval_d = 1'b0;
      end
      if (wb_we_i) begin
        case (wb_adr_i)
          OFS_ADDR: adr_d = mrg[27:0];
          OFS_LEN: len_d = mrg[11:0];
          OFS_DATA: begin
            if (wb_sel_i[0]) begin
              wbyte_d = wb_dat_i[7:0];
              wval_d = 1'b1;
            end
          end
          OFS_CTRL: begin
            if (wb_sel_i[0]) begin
              wpn_d = wb_dat_i[4];
              // a start is refused while busy or when the sequence would be illegal
              if (st_q != E_IDLE || opn == OP_NONE || opn > OP_STAT) refuse = 1'b1;
              if (!rb_n_i && opn != OP_STAT) refuse = 1'b1;
              if (opn == OP_RDCOL && !rdok_q) refuse = 1'b1;
              if (opn == OP_WRCOL && !open_q) refuse = 1'b1;
              if (opn == OP_PROG && lrow_v_q && adr_q[27:12] == lrow_q
                  && pcnt_q == PART_MAX) refuse = 1'b1;
              if (opn == OP_PROG && lrow_v_q && adr_q[27:18] == lrow_q[15:6]
                  && adr_q[17:12] < lrow_q[5:0]) refuse = 1'b1;
              err_d = refuse;
              if (!refuse) begin
                op_d = opn;
                conf_d = wb_dat_i[3];
                cnt_d = 12'h000;
                acnt_d = 3'h0;
                st_d = E_CMD1;
                if (opn == OP_READ || opn == OP_PROG || opn == OP_ID) begin
                  rdok_d = 1'b0;
                  open_d = 1'b0;
                end
                if (opn == OP_PROG) begin
                  open_d = 1'b1;
                  lrow_d = adr_q[27:12];
                  lrow_v_d = 1'b1;
                  pcnt_d = (lrow_v_q && adr_q[27:12] == lrow_q) ? pcnt_q + 3'h1 : 3'h1;
                end
              end
            end
          end
          default: ;
        endcase
      end
    end
    // engine: each pin cycle is a req pulse, then a wait for done
    case (st_q)
      E_IDLE: ;
      E_CMD1: begin
        if (!pend_q) begin
          req_d = 1'b1;
          pend_d = 1'b1;
          kind_d = K_CMD;
          case (op_q)
            OP_READ: wd_d = CMD_READ;
            OP_RDCOL: wd_d = CMD_ROUT;
            OP_PROG: wd_d = CMD_LOAD;
            OP_WRCOL: wd_d = CMD_RIN;
            OP_ID: wd_d = CMD_ID;
            default: wd_d = CMD_STAT;
          endcase
        end else if (cy.done) begin
          pend_d = 1'b0;
          if (op_q == OP_STAT) begin
            gap_d = CYC_WHR;
            gnx_d = E_SRD;
            st_d = E_GAP;
          end else begin
            st_d = E_ADDR;
          end
        end
      end
      E_ADDR: begin
        if (!pend_q) begin
          req_d = 1'b1;
          pend_d = 1'b1;
          kind_d = K_ADR;
          wd_d = abyte(acnt_q, adr_q, op_q);
        end else if (cy.done) begin
          pend_d = 1'b0;
          acnt_d = acnt_q + 3'h1;
          if (op_q == OP_ID || acnt_q == ADDR_LAST
              || (acnt_q == 3'h1 && (op_q == OP_RDCOL || op_q == OP_WRCOL))) begin
            if (op_q == OP_READ || op_q == OP_RDCOL) begin
              st_d = E_CMD2;
            end else begin
              gap_d = (op_q == OP_ID) ? CYC_WHR : CYC_ADL;
              gnx_d = E_XFER;
              st_d = E_GAP;
            end
          end
        end
      end
      E_CMD2: begin
        if (!pend_q) begin
          req_d = 1'b1;
          pend_d = 1'b1;
          kind_d = K_CMD;
          wd_d = (op_q == OP_READ) ? CMD_READ_GO : ((op_q == OP_RDCOL) ? CMD_ROUT_GO
                                                                   : CMD_PROG_GO);
        end else if (cy.done) begin
          pend_d = 1'b0;
          if (!is_rd(op_q)) open_d = 1'b0;
          gap_d = CYC_WB;
          gnx_d = E_RDY;
          st_d = E_GAP;
        end
      end
      E_GAP: begin
        if (gap_q <= 8'h01) st_d = gnx_q;
        else gap_d = gap_q - 8'h01;
      end
      E_RDY: begin
        if (rb_n_i) begin
          if (op_q == OP_READ) rdok_d = 1'b1;
          st_d = is_rd(op_q) ? E_XFER : E_SCMD;
        end
      end
      E_XFER: begin
        if (!pend_q && cnt_q == ((op_q == OP_ID) ? ID_LEN : len_q)) begin
          if (!is_rd(op_q) && conf_q) begin
            st_d = E_CMD2;
          end else begin
            gap_d = CYC_RHW;
            gnx_d = E_IDLE;
            st_d = E_GAP;
          end
        end else if (!pend_q) begin
          if (is_rd(op_q) && !rval_q) begin
            req_d = 1'b1;
            pend_d = 1'b1;
            kind_d = K_RD;
          end else if (!is_rd(op_q) && wval_q) begin
            req_d = 1'b1;
            pend_d = 1'b1;
            kind_d = K_WR;
            wd_d = wbyte_q;
            wval_d = 1'b0;
          end
        end else if (cy.done) begin
          pend_d = 1'b0;
          cnt_d = cnt_q + 12'h001;
          if (op_q == OP_ID) begin
            id_d[cnt_q[1:0]*8 +: 8] = cy.rdata;
          end else if (is_rd(op_q)) begin
            rbyte_d = cy.rdata;
            rval_d = 1'b1;
          end
        end
      end
      E_SCMD: begin
        if (!pend_q) begin
          req_d = 1'b1;
          pend_d = 1'b1;
          kind_d = K_CMD;
          wd_d = CMD_STAT;
        end else if (cy.done) begin
          pend_d = 1'b0;
          gap_d = CYC_WHR;
          gnx_d = E_SRD;
          st_d = E_GAP;
        end
      end
      E_SRD: begin
        if (!pend_q) begin
          req_d = 1'b1;
          pend_d = 1'b1;
          kind_d = K_RD;
        end else if (cy.done) begin
          pend_d = 1'b0;
          stat_d = cy.rdata;
          gap_d = CYC_RHW;
          gnx_d = E_IDLE;
          st_d = E_GAP;
        end
      end
      default: st_d = E_IDLE;
    endcase
  end

  // register all state
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st_q <= E_IDLE; gnx_q <= E_IDLE; op_q <= OP_NONE; conf_q <= 1'b0;
      adr_q <= 28'h0; len_q <= 12'h0; cnt_q <= 12'h0; acnt_q <= 3'h0;
      gap_q <= 8'h0; pend_q <= 1'b0; req_q <= 1'b0; kind_q <= K_CMD; wd_q <= 8'h0;
      wbyte_q <= 8'h0; rbyte_q <= 8'h0; wval_q <= 1'b0; rval_q <= 1'b0;
      err_q <= 1'b0; stat_q <= 8'h0; id_q <= 32'h0; lrow_q <= 16'h0;
      lrow_v_q <= 1'b0; pcnt_q <= 3'h0; open_q <= 1'b0; rdok_q <= 1'b0;
      wpn_q <= 1'b0; ack_q <= 1'b0; dat_q <= 32'h0;
    end else begin
      st_q <= st_d; gnx_q <= gnx_d; op_q <= op_d; conf_q <= conf_d;
      adr_q <= adr_d; len_q <= len_d; cnt_q <= cnt_d; acnt_q <= acnt_d;
      gap_q <= gap_d; pend_q <= pend_d; req_q <= req_d; kind_q <= kind_d; wd_q <= wd_d;
      wbyte_q <= wbyte_d; rbyte_q <= rbyte_d; wval_q <= wval_d; rval_q <= rval_d;
      err_q <= err_d; stat_q <= stat_d; id_q <= id_d; lrow_q <= lrow_d;
      lrow_v_q <= lrow_v_d; pcnt_q <= pcnt_d; open_q <= open_d; rdok_q <= rdok_d;
      wpn_q <= wpn_d; ack_q <= ack_d; dat_q <= dat_d;
    end
  end

  // chip enable is let go while the engine waits on software for data
  assign cy.ce_on = (st_q != E_IDLE) && !(st_q == E_XFER && !pend_q);
  assign cy.req = req_q;
  assign cy.kind = kind_q;
  assign cy.wdata = wd_q;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign wp_n_o = wpn_q;

  nfc_cycle u_cyc (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .c(cy.cyc),
    .ce_n_o(ce_n_o),
    .cle_o(cle_o),
    .ale_o(ale_o),
    .we_n_o(we_n_o),
    .output_strobe_n_o(output_strobe_n_o),
    .io_o(io_o),
    .io_oe_o(io_oe_o),
    .io_i(io_i)
  );
endmodule : nfc_top
`default_nettype wire

//--- dv/nfc_flash_model.sv
// nfc_flash_model.sv: behavioural byte-wide flash device facing the host engine
`timescale 1ns/1ps
`default_nettype none
module nfc_flash_model #(
  parameter logic [7:0] MAKER = 8'h5a, // arbitrary value
  parameter logic [7:0] DEVC = 8'h3c, // arbitrary value
  parameter logic [7:0] GEOB = 8'h95 // 2KB page, 128KB block, 16 spare, x8, 25ns
) (
  input wire logic ce_n_i, cle_i, ale_i, we_n_i, output_strobe_n_i, wp_n_i,
  input wire logic [7:0] io_i,
  output logic [7:0] io_o,
  output logic rb_n_o
);
  logic [7:0] cmd = 8'h00; // read setup assumed from power-up
  logic [2:0] na = 3'h0;
  logic [1:0] idn = 2'h0;
  logic [11:0] col = 12'h000;
  logic [7:0] dout = 8'h00, last_in = 8'h00;
  logic busy = 1'b0, drv = 1'b0;
  assign rb_n_o = ~busy;
  // released bus shows the inverse so a stale byte never passes
  assign io_o = drv ? dout : ~dout;
  // latch command, address and data on the write strobe rise
  always @(posedge we_n_i) if (!ce_n_i) begin
    if (cle_i) begin
      cmd <= io_i;
      na <= 3'h0;
      idn <= 2'h0;
      if (io_i == 8'h30 || io_i == 8'h10) begin
        busy <= 1'b1;
        busy <= #400 1'b0;
      end
    end else if (ale_i) begin
      if (na == 3'h0) col[7:0] <= io_i;
      if (na == 3'h1) col[11:8] <= io_i[3:0];
      na <= na + 3'h1;
    end else begin
      last_in <= io_i;
      col <= col + 12'h001;
    end
  end
  // each strobe fall presents the next byte
  // chip enable and strobe may fall in one step, so act on whichever falls last
  always @(negedge output_strobe_n_i or negedge ce_n_i)
    if (!ce_n_i && !output_strobe_n_i) begin
    drv <= 1'b1;
    if (cmd == 8'h90) begin
      dout <= (idn == 2'h0) ? MAKER : (idn == 2'h1) ? DEVC : (idn == 2'h2) ? 8'h00 : GEOB;
      idn <= idn + 2'h1;
    end else if (cmd == 8'h70) begin
      // program verify here never finds a stuck one, so the fail bit stays zero
      dout <= {wp_n_i, ~busy, 6'h00};
    end else begin
      dout <= col[7:0] ^ {4'h0, col[11:8]};
      col <= col + 12'h001;
    end
  end
  always @(posedge output_strobe_n_i) drv <= #10 1'b0;
endmodule : nfc_flash_model
`default_nettype wire

//--- dv/nfc_top_monitor.sv
// nfc_top_monitor.sv: pin and bus timing checks on the host engine
`timescale 1ns/1ps
`default_nettype none
module nfc_top_monitor (
  input wire logic mclk_i, reset_i, wb_cyc_i, wb_stb_i, wb_ack_o,
  input wire logic ce_n_o, cle_o, ale_o, we_n_o, output_strobe_n_o, io_oe_o,
  input wire logic [7:0] io_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  strobe_excl_a: assert property (we_n_o || output_strobe_n_o) else $error("both strobes");
  latch_excl_a: assert property (!(cle_o && ale_o)) else $error("both latches");
  we_width_a: assert property ($fell(we_n_o) |-> !we_n_o [*6] ##1 we_n_o) else $error("we width");
  re_width_a: assert property ($fell(output_strobe_n_o) |-> !output_strobe_n_o [*7] ##1 output_strobe_n_o)
    else $error("read strobe width");
  ce_strobe_a: assert property (!(we_n_o && output_strobe_n_o) |-> !ce_n_o) else $error("no ce");
  write_drive_a: assert property (!we_n_o |-> io_oe_o) else $error("io not driven");
  read_free_a: assert property (!output_strobe_n_o |-> !io_oe_o) else $error("io clash");
  latch_hold_a: assert property (!we_n_o && $past(!we_n_o) |-> $stable(io_o) && $stable(cle_o))
    else $error("byte moved in strobe");
endmodule : nfc_top_monitor
bind nfc_top nfc_top_monitor mon (.mclk_i, .reset_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .ce_n_o,
  .cle_o, .ale_o, .we_n_o, .output_strobe_n_o, .io_oe_o, .io_o);
`default_nettype wire

//--- dv/tb_top.sv
// tb_top.sv: self-checking bench of the host engine against the flash model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import nfc_pkg::*;
  logic mclk_i = 1'b0, reset_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h0, rdat = 32'h0;
  wire logic [31:0] dat_o;
  wire logic ack, ce_n, cle, ale, we_n, os_n, wp_n, oe, rb_n;
  wire logic [7:0] io_o, io_i;
  int error_cnt = 0, checks_done = 0, cyc_cnt = 0;
  typedef struct {logic [31:0] op; logic [4:0] ra; logic [31:0] exp, msk;} nfc_row_t;
  // start op, register to read, expected value and mask
  nfc_row_t rows [5] = '{'{32'h15, OFS_IDW, 32'h95003c5a, 32'hffffffff},
    '{32'h15, OFS_GEOM, 32'h01408002, 32'hffffffff}, '{32'h16, OFS_STAT, 32'hc032, 32'hffff},
    '{32'h17, OFS_STAT, 32'h4, 32'h4}, '{32'h10, OFS_STAT, 32'h4, 32'h4}};
  nfc_top DUT (.mclk_i, .reset_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .ce_n_o(ce_n),
    .cle_o(cle), .ale_o(ale), .we_n_o(we_n), .output_strobe_n_o(os_n), .wp_n_o(wp_n),
    .io_o(io_o), .io_oe_o(oe), .io_i(io_i), .rb_n_i(rb_n));
  nfc_flash_model flash (.ce_n_i(ce_n), .cle_i(cle), .ale_i(ale), .we_n_i(we_n),
    .output_strobe_n_i(os_n), .wp_n_i(wp_n), .io_i(io_o), .io_o(io_i), .rb_n_o(rb_n));
  initial forever #2.5 mclk_i = ~mclk_i;
  // one classic cycle: hold until ack is sampled, then release for a cycle
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do @(posedge mclk_i); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge mclk_i);
  endtask : wb
  // poll the engine busy flag, bounded
  task automatic idle();
    repeat (400) begin
      wb(1'b0, OFS_STAT, 32'h0);
      if (rdat[0] === 1'b0) break;
    end
    if (rdat[0] !== 1'b0) begin
      error_cnt++;
      $display("Error %0t: engine stays busy", $time);
    end
  endtask : idle
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
    checks_done++;
    if ((g & m) !== (e & m)) begin
      error_cnt++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic give_verdict();
    if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  // hang guard, well above the few thousand cycles the run needs
  always @(posedge mclk_i) if (++cyc_cnt == 40000) begin
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge mclk_i);
    chk({27'h0, ce_n, wp_n, we_n, os_n, oe}, 32'h16, 32'h1f);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    foreach (rows[i]) begin
      wb(1'b1, OFS_CTRL, rows[i].op);
      idle();
      wb(1'b0, rows[i].ra, 32'h0);
      chk(rdat, rows[i].exp, rows[i].msk);
    end
    wb(1'b1, OFS_ADDR, 32'h0003005);
    wb(1'b1, OFS_LEN, 32'h2);
    wb(1'b1, OFS_CTRL, 32'h11);
    wb(1'b0, OFS_DATA, 32'h0);
    chk(rdat, 32'h05, 32'hff);
    wb(1'b0, OFS_DATA, 32'h0);
    chk(rdat, 32'h06, 32'hff);
    idle();
    wb(1'b1, OFS_ADDR, 32'h00037ff);
    wb(1'b1, OFS_LEN, 32'h1);
    wb(1'b1, OFS_CTRL, 32'h12);
    wb(1'b0, OFS_DATA, 32'h0);
    chk(rdat, 32'hf8, 32'hff);
    idle();
    wb(1'b1, OFS_ADDR, 32'h0003010);
    wb(1'b1, OFS_CTRL, 32'h1b);
    wb(1'b1, OFS_DATA, 32'ha5);
    idle();
    wb(1'b0, OFS_STAT, 32'h0);
    chk(rdat, 32'h32, 32'h3f);
    chk({24'h0, flash.last_in}, 32'ha5, 32'hff);
    wb(1'b1, OFS_ADDR, 32'h0002010);
    wb(1'b1, OFS_CTRL, 32'h1b);
    wb(1'b0, OFS_STAT, 32'h0);
    chk(rdat, 32'h4, 32'h4);
    wb(1'b1, OFS_ADDR, 32'h0004010);
    wb(1'b1, OFS_CTRL, 32'h13);
    wb(1'b1, OFS_DATA, 32'h11);
    idle();
    wb(1'b1, OFS_CTRL, 32'h1c);
    wb(1'b1, OFS_DATA, 32'h3c);
    idle();
    wb(1'b0, OFS_STAT, 32'h0);
    chk(rdat, 32'h32, 32'h3f);
    chk({24'h0, flash.last_in}, 32'h3c, 32'hff);
    wb(1'b0, 5'h1c, 32'h0);
    chk(rdat, 32'h0, 32'hffffffff);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
